// ===== hdl/nvm_timer_map.svh
// Offsets, field positions, reset values and counts of the interval timer.
// Included by its bare name; definitions only.
`ifndef NVM_TIMER_MAP_SVH
`define NVM_TIMER_MAP_SVH

// Register indices; the APB byte address is four times the index.
`define IDX_POINTER      8'h01
`define IDX_DATA         8'h03
`define IDX_CONTROL      8'h04
`define IDX_RELOAD       8'h05
`define IDX_COUNT        8'h06

// Control register field positions.
`define CTL_RUN          7
`define CTL_IE           6
`define CTL_FLAG         5
`define CTL_START        4
`define CTL_MODE_HI      3
`define CTL_MODE_LO      1

// Mode codes held in bits 3 to 1.
`define MODE_WRITE       3'h2
`define MODE_ERASE_WRITE 3'h4
`define MODE_ERASE       3'h7

// Reset values.
`define RESET_BYTE       8'h00
`define RESET_POINTER    7'h00
`define RESET_MODE       3'h0

// Crystal clock periods per counter decrement.
`define PRESCALE         9'd480
`define PRESCALE_W       9

`endif

// ===== hdl/nvm_timer_pkg.sv
// Types shared by the interval timer and its tick divider.
// Assumes nvm_timer_map.svh supplies the numeric constants.
`include "nvm_timer_map.svh"

package nvm_timer_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_GENERAL,
        ST_CYCLE_FIRST,
        ST_CYCLE_LAST
    } tmrState_type;

    // Interrupt context from the processor core.
    typedef struct packed {
        logic inService;
        logic extPending;
        logic globalEnable;
    } irqCtx_type;

    // Towards the memory array datapath.
    typedef struct packed {
        logic [6:0] pointer;
        logic [7:0] data;
        logic       eraseOn;
        logic       writeOn;
        logic       done;
    } nvmPort_type;

    typedef struct packed {
        tmrState_type state;
        logic         run;
        logic         ie;
        logic         flag;
        logic         start;
        logic [2:0]   mode;
        logic [2:0]   cycleMode;
        logic [7:0]   reload;
        logic [7:0]   count;
        logic [6:0]   pointer;
        logic [7:0]   data;
        logic         pready;
        logic         pslverr;
        logic [7:0]   rdata;
        logic         irq;
        logic         eraseOn;
        logic         writeOn;
        logic         done;
    } timerRegs_type;

    typedef struct packed {
        logic [`PRESCALE_W-1:0] cnt;
        logic                   tick;
    } divRegs_type;

endpackage : nvm_timer_pkg

// ===== hdl/tick_divider.sv
// Divides the crystal clock by the prescale count into a one-cycle tick.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/100ps
`include "nvm_timer_map.svh"

module tick_divider (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // Control
    input  wire logic hold,
    input  wire logic restart,
    // Enable out
    output logic      tick
);
    import nvm_timer_pkg::*;

    divRegs_type s_q;
    divRegs_type s_d;

    always_comb begin
        s_d = s_q;
        // Restart aligns the first interval with a counter load.
        // Hold keeps a pending tick, so entering Stop never loses a step.
        if (restart) begin
            s_d.cnt = '0;
            s_d.tick = 1'b0;
        end else if (!hold) begin
            s_d.tick = 1'b0;
            if (s_q.cnt == `PRESCALE - 9'd1) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 9'd1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : tick_divider

// ===== hdl/nvm_interval_timer.sv
// Interval timer for the memory page cycles, with its control registers.
// Assumes an APB master on mclk and the core's interrupt context inputs.
//
// What this block does
// - Cycle ends at second underflow (erase/write) or first; stop, flag, clear.
// - Setting the run bit loads the counter from reload, then counts down.
// - Free-running mode reloads, sets the flag and keeps counting.
// - Clearing the run bit stops at once and holds the count.
// - Setting the run bit again restarts from the reload value.
// - The count reads back while running without disturbing it.
// - A set underflow flag gated by the enable makes the interrupt.
// - Request only when not in service, no external, globally enabled.
// - Software may set the flag, giving a software interrupt.
// - Reset clears every register to zero.
// - In Idle the timer and page cycle keep running.
// - In Stop the timer freezes and later resumes from held state.
// - Reload register at index 05, read-only count at index 06.
// - Control: run, enable, flag, start, mode 3..1, bit 0 zero.
// - Eight-bit down-counter stepped every 480 crystal periods.
// - Setting cycle start loads the counter and counts down.
// - Erase/write reloads after the first underflow for the write.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "nvm_timer_map.svh"

module nvm_interval_timer (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       srst,
    // APB slave
    input  wire logic [7:0]                 paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Power modes
    input  wire logic                       idleMode,
    input  wire logic                       stopMode,
    // Interrupt
    input  wire nvm_timer_pkg::irqCtx_type  irqCtx,
    output logic                            irqRequest,
    // Memory array side
    output nvm_timer_pkg::nvmPort_type      nvmPort
);
    import nvm_timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    timerRegs_type s_q;
    timerRegs_type s_d;
    logic          tick;
    logic          restart;

    function automatic logic hitReg(input logic [7:0] addr,
                                    input logic [7:0] idx);
        hitReg = (addr == {idx[5:0], 2'b00});
    endfunction : hitReg

    // Idle mode gates only the core, so the timer ignores it.
    tick_divider divider (
        .mclk    (mclk),
        .srst    (srst),
        .hold    (stopMode),
        .restart (restart),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////

    logic setupPh;
    logic wrAcc;
    logic mapped;
    logic loaded;
    logic isEw;

    always_comb begin
        s_d = s_q;
        restart = 1'b0;
        loaded = 1'b0;
        s_d.pready = 1'b0;
        s_d.done = 1'b0;
        setupPh = psel && !penable;
        wrAcc = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
        mapped = hitReg(paddr, `IDX_POINTER) || hitReg(paddr, `IDX_DATA)
              || hitReg(paddr, `IDX_CONTROL) || hitReg(paddr, `IDX_RELOAD)
              || hitReg(paddr, `IDX_COUNT);
        // Read data is captured in the setup cycle and answered next cycle.
        if (setupPh) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !mapped || (pwrite && hitReg(paddr, `IDX_COUNT));
            s_d.rdata = `RESET_BYTE;
            if (!pwrite) begin
                if (hitReg(paddr, `IDX_POINTER)) begin
                    s_d.rdata = {1'b0, s_q.pointer};
                end
                if (hitReg(paddr, `IDX_DATA)) begin
                    s_d.rdata = s_q.data;
                end
                if (hitReg(paddr, `IDX_CONTROL)) begin
                    s_d.rdata = {s_q.run, s_q.ie, s_q.flag, s_q.start,
                                 s_q.mode, 1'b0};
                end
                if (hitReg(paddr, `IDX_RELOAD)) begin
                    s_d.rdata = s_q.reload;
                end
                if (hitReg(paddr, `IDX_COUNT)) begin
                    s_d.rdata = s_q.count;
                end
            end
        end
        if (wrAcc) begin
            if (hitReg(paddr, `IDX_POINTER)) begin
                s_d.pointer = pwdata[6:0];
            end
            if (hitReg(paddr, `IDX_DATA)) begin
                s_d.data = pwdata[7:0];
            end
            if (hitReg(paddr, `IDX_RELOAD)) begin
                s_d.reload = pwdata[7:0];
            end
            if (hitReg(paddr, `IDX_CONTROL)) begin
                s_d.run = pwdata[`CTL_RUN];
                s_d.ie = pwdata[`CTL_IE];
                s_d.flag = pwdata[`CTL_FLAG];
                s_d.start = pwdata[`CTL_START];
                s_d.mode = pwdata[`CTL_MODE_HI:`CTL_MODE_LO];
                if (pwdata[`CTL_START] && !s_q.start) begin
                    // A page cycle takes the timer over from free running.
                    s_d.state = ST_CYCLE_FIRST;
                    s_d.cycleMode = pwdata[`CTL_MODE_HI:`CTL_MODE_LO];
                    s_d.count = s_q.reload;
                    restart = 1'b1;
                    loaded = 1'b1;
                end else if (!pwdata[`CTL_START] && s_q.start) begin
                    // Clearing start aborts the cycle; the count is held.
                    s_d.state = ST_IDLE;
                end else if (!s_q.start) begin
                    if (pwdata[`CTL_RUN] && !s_q.run) begin
                        s_d.state = ST_GENERAL;
                        s_d.count = s_q.reload;
                        restart = 1'b1;
                        loaded = 1'b1;
                    end else if (!pwdata[`CTL_RUN]) begin
                        s_d.state = ST_IDLE;
                    end
                end
            end
        end
        isEw = (s_q.cycleMode == `MODE_ERASE_WRITE);
        // Underflow comes after the write so hardware's flag set wins.
        if (tick && !stopMode && !loaded && s_q.state != ST_IDLE) begin
            if (s_q.count != 8'h00) begin
                s_d.count = s_q.count - 8'h01;
            end else begin
                s_d.count = s_q.reload;
                s_d.flag = 1'b1;
                if (s_q.state == ST_CYCLE_FIRST && isEw) begin
                    s_d.state = ST_CYCLE_LAST;
                end else if (s_q.state != ST_GENERAL) begin
                    s_d.state = ST_IDLE;
                    s_d.start = 1'b0;
                    s_d.mode = `RESET_MODE;
                    s_d.done = 1'b1;
                end
            end
        end
        s_d.eraseOn = (s_d.state == ST_CYCLE_FIRST)
                   && (s_d.cycleMode == `MODE_ERASE_WRITE
                       || s_d.cycleMode == `MODE_ERASE);
        s_d.writeOn = (s_d.state == ST_CYCLE_LAST)
                   || ((s_d.state == ST_CYCLE_FIRST) && !s_d.eraseOn);
        s_d.irq = s_d.flag && s_d.ie && !irqCtx.inService
               && !irqCtx.extPending && irqCtx.globalEnable;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = {24'h000000, s_q.rdata};
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irqRequest = s_q.irq;
    assign nvmPort = '{pointer: s_q.pointer, data: s_q.data,
                       eraseOn: s_q.eraseOn, writeOn: s_q.writeOn,
                       done: s_q.done};

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    logic ctlWrite;
    assign ctlWrite = wrAcc && hitReg(paddr, `IDX_CONTROL);

    a_reset_clear: assert property (
        @(posedge mclk) disable iff (1'b0)
        srst |=> (s_q.count == 8'h00 && s_q.reload == 8'h00
                  && !s_q.flag && s_q.state == ST_IDLE && !irqRequest))
        else $error("registers not cleared by reset");

    a_count_step: assert property (
        (tick && !stopMode && !wrAcc && s_q.state != ST_IDLE
         && s_q.count != 8'h00) |=> s_q.count == $past(s_q.count) - 8'h01)
        else $error("counter did not decrement on tick");

    a_gen_reload: assert property (
        (tick && !stopMode && !wrAcc && s_q.state == ST_GENERAL
         && s_q.count == 8'h00)
        |=> (s_q.count == $past(s_q.reload) && s_q.flag
             && s_q.state == ST_GENERAL))
        else $error("free-running underflow wrong");

    a_cycle_end: assert property (
        (tick && !stopMode && !wrAcc && s_q.count == 8'h00
         && (s_q.state == ST_CYCLE_LAST
             || (s_q.state == ST_CYCLE_FIRST && s_q.cycleMode != 3'h4)))
        |=> (s_q.state == ST_IDLE && !s_q.start && s_q.mode == 3'h0
             && s_q.flag && nvmPort.done) ##1 !nvmPort.done)
        else $error("page cycle did not end cleanly");

    a_ew_second: assert property (
        (tick && !stopMode && !wrAcc && s_q.state == ST_CYCLE_FIRST
         && s_q.cycleMode == 3'h4 && s_q.count == 8'h00)
        |=> (s_q.state == ST_CYCLE_LAST && s_q.count == $past(s_q.reload)
             && nvmPort.writeOn && !nvmPort.eraseOn))
        else $error("erase phase did not hand over to write");

    a_stop_hold: assert property (
        (s_q.state == ST_IDLE && !ctlWrite) |=> $stable(s_q.count))
        else $error("stopped counter moved");

    a_freeze_hold: assert property (
        (stopMode && !wrAcc) [*2] |-> $stable(s_q.count))
        else $error("counter moved in stop mode");

    a_run_load: assert property (
        (ctlWrite && pwdata[7] && !s_q.run && !s_q.start && !pwdata[4])
        |=> (s_q.state == ST_GENERAL && s_q.count == $past(s_q.reload)))
        else $error("run did not reload the counter");

    a_irq_gate: assert property (
        irqRequest |-> (s_q.flag && s_q.ie && $past(irqCtx.globalEnable)
                        && !$past(irqCtx.inService)
                        && !$past(irqCtx.extPending)))
        else $error("interrupt raised without its conditions");

    a_bus_answer: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("APB answer not one cycle");

    a_idle_runs: assert property (
        (idleMode && tick && !stopMode && !wrAcc && s_q.state != ST_IDLE)
        |=> s_q.count == (($past(s_q.count) == 8'h00) ? $past(s_q.reload)
                          : $past(s_q.count) - 8'h01))
        else $error("timer stalled in idle mode");

    a_start_load: assert property (
        (ctlWrite && pwdata[4] && !s_q.start)
        |=> (s_q.state == ST_CYCLE_FIRST && s_q.count == $past(s_q.reload)
             && s_q.cycleMode == s_q.mode))
        else $error("cycle start did not load the counter");

    a_count_refused: assert property (
        (psel && !penable && pwrite && hitReg(paddr, `IDX_COUNT))
        |=> (pready && pslverr))
        else $error("count register write not refused");

    a_soft_flag: assert property (
        (ctlWrite && pwdata[5]) |=> s_q.flag)
        else $error("software could not set the flag");

    a_irq_follow: assert property (
        (s_q.flag && s_q.ie && irqCtx.globalEnable && !irqCtx.inService
         && !irqCtx.extPending && !ctlWrite) |=> irqRequest)
        else $error("interrupt missing while enabled");

    a_read_count: assert property (
        (psel && !penable && !pwrite && hitReg(paddr, `IDX_COUNT))
        |=> prdata[7:0] == $past(s_q.count))
        else $error("count read back wrong");

    a_ctl_bit0: assert property (
        (psel && !penable && !pwrite && hitReg(paddr, `IDX_CONTROL))
        |=> !prdata[0])
        else $error("control bit 0 not zero");

    c_gen_underflow: cover property (
        s_q.state == ST_GENERAL && tick && s_q.count == 8'h00);
    c_ew_done: cover property (
        s_q.state == ST_CYCLE_LAST ##1 nvmPort.done);
    c_erase_done: cover property (
        s_q.cycleMode == 3'h7 && nvmPort.done);
    c_soft_irq: cover property (
        ctlWrite && pwdata[5] && !s_q.flag ##1 irqRequest);

endmodule : nvm_interval_timer

// ===== tb/tb_top.sv
// Self-checking bench for the interval timer, driven over its APB port.
// Assumes the design package and the map header are on the include path.
`timescale 1ns/100ps
`include "nvm_timer_map.svh"

module tb_top;
    import nvm_timer_pkg::*;

    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idleMode = 1'b0;
    logic        stopMode = 1'b0;
    irqCtx_type  irqCtx = '0;
    logic        irqRequest;
    nvmPort_type nvmPort;
    int          errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          t0;
    int          n;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  regIdx [5] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06};
    logic [2:0]  modes [3] = '{`MODE_WRITE, `MODE_ERASE_WRITE, `MODE_ERASE};

    always #10 mclk = ~mclk;

    nvm_interval_timer uut (
        .mclk       (mclk),
        .srst       (srst),
        .paddr      (paddr),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .idleMode   (idleMode),
        .stopMode   (stopMode),
        .irqCtx     (irqCtx),
        .irqRequest (irqRequest),
        .nvmPort    (nvmPort)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // The whole sequence needs about 8300 cycles.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is sampled high.
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic waitTo(input int t);
        while (cyc < t)
            @(posedge mclk);
    endtask : waitTo

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rdchk(regIdx[i], 32'h0);
        end
        xfer(1'b1, 8'h05, 32'h02);
        rdchk(8'h05, 32'h02);
        xfer(1'b1, 8'h06, 32'h55);
        chk(er, 1'b1);
        rdchk(8'h06, 32'h00);
        xfer(1'b0, 8'h02, 32'h0);
        chk(er, 1'b1);
        xfer(1'b1, 8'h04, 32'h0F);
        rdchk(8'h04, 32'h0E);
        xfer(1'b1, 8'h04, 32'h00);
        $display("test registers done");

        // Free-running timer: one tick every 480 cycles after the load.
        xfer(1'b1, 8'h04, 32'h80);
        t0 = cyc;
        rdchk(8'h06, 32'h02);
        waitTo(t0 + 700);
        rdchk(8'h06, 32'h01);
        waitTo(t0 + 1700);
        rdchk(8'h04, 32'hA0);
        rdchk(8'h06, 32'h02);
        waitTo(t0 + 2100);
        xfer(1'b1, 8'h04, 32'h00);
        waitTo(t0 + 2700);
        rdchk(8'h06, 32'h01);
        xfer(1'b1, 8'h04, 32'h80);
        rdchk(8'h06, 32'h02);
        xfer(1'b1, 8'h04, 32'h00);
        $display("test general timer done");

        // A thousand frozen cycles push every later tick back by as much.
        xfer(1'b1, 8'h04, 32'h80);
        t0 = cyc;
        rdchk(8'h04, 32'h80);
        waitTo(t0 + 100);
        stopMode <= 1'b1;
        waitTo(t0 + 1100);
        stopMode <= 1'b0;
        waitTo(t0 + 1300);
        rdchk(8'h06, 32'h02);
        waitTo(t0 + 1600);
        rdchk(8'h06, 32'h01);
        xfer(1'b1, 8'h04, 32'h00);
        $display("test stop mode done");

        irqCtx <= 3'b001;
        xfer(1'b1, 8'h04, 32'h60);
        repeat (3) @(posedge mclk);
        chk(irqRequest, 1'b1);
        for (int i = 0; i < 3; i++) begin
            irqCtx <= 3'b001 ^ (3'b100 >> i);
            repeat (3) @(posedge mclk);
            chk(irqRequest, 1'b0);
        end
        irqCtx <= 3'b001;
        xfer(1'b1, 8'h04, 32'h20);
        repeat (3) @(posedge mclk);
        chk(irqRequest, 1'b0);
        rdchk(8'h04, 32'h20);
        xfer(1'b1, 8'h04, 32'h00);
        rdchk(8'h04, 32'h00);
        $display("test interrupt done");

        // Page cycles run in Idle, so idleMode stays high throughout.
        xfer(1'b1, 8'h05, 32'h01);
        idleMode <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            n = (modes[i] == `MODE_ERASE_WRITE) ? 2 : 1;
            xfer(1'b1, 8'h04, {24'h0, 4'h1, modes[i], 1'b0});
            t0 = cyc;
            waitTo(t0 + 100);
            chk({nvmPort.eraseOn, nvmPort.writeOn},
                (modes[i] == `MODE_WRITE) ? 2'b01 : 2'b10);
            if (n == 2) begin
                waitTo(t0 + 1100);
                chk({nvmPort.eraseOn, nvmPort.writeOn}, 2'b01);
            end
            while (nvmPort.done !== 1'b1 && cyc < t0 + 3000)
                @(posedge mclk);
            chk(cyc - t0 >= 960 * n - 3 && cyc - t0 <= 960 * n + 3,
                1'b1);
            rdchk(8'h04, 32'h20);
            xfer(1'b1, 8'h04, 32'h00);
        end
        $display("test page cycles done");

        // A reset in mid-run must clear what the bench has written.
        xfer(1'b1, 8'h01, 32'hFF);
        xfer(1'b1, 8'h03, 32'hA5);
        xfer(1'b1, 8'h05, 32'h25);
        chk({nvmPort.pointer, nvmPort.data}, 15'h7FA5);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chk({nvmPort.pointer, nvmPort.data}, 15'h0);
        for (int i = 0; i < 5; i++) begin
            rdchk(regIdx[i], 32'h0);
        end
        $display("test mid-run reset done");
        results();
    end

endmodule : tb_top
